// *** common/mfg_pkg.sv ***
// Purpose: Shared constants and types of the mode and fuse-row guard.
// Assumes: Byte-wide non-volatile memory, 32-bit APB register port.
// Notes:   Row offsets are relative to the base of the protected row.
package mfg_pkg;

  // ---------------------------------------------------------------
  // Protected row layout
  // ---------------------------------------------------------------
  localparam int unsigned ROW_BYTES = 512;
  localparam logic [8:0] RO_OFF = 9'h000;
  localparam logic [8:0] RO_LEN = 9'h020;
  localparam logic [8:0] WP_OFF = 9'h020;
  localparam logic [8:0] WP_LEN = 9'h010;
  localparam logic [8:0] WO_OFF = 9'h040;
  localparam logic [8:0] WO_LEN = 9'h020;
  localparam logic [8:0] PDC_OFF = 9'h080;
  localparam logic [8:0] PDC_LEN = 9'h040;
  localparam logic [8:0] CFG_OFF = 9'h100;
  localparam logic [8:0] CFG_LEN = 9'h004;

  // Fuse bytes, in load order
  localparam logic [1:0] CFG_SEC = 2'h0;
  localparam logic [1:0] CFG_OPT = 2'h1;
  localparam logic [1:0] CFG_CRC = 2'h2;
  localparam logic [1:0] CFG_STATE = 2'h3;

  // Option byte bits
  localparam int OPT_CD_EN = 0;
  localparam int OPT_ER_EN = 1;
  localparam int OPT_DELIV = 2;
  // State byte bits
  localparam int SB_WP = 0;
  localparam int SB_CD = 1;

  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] ERASE_VAL = 8'h00;
  localparam logic [7:0] SEC_FAILSAFE = 8'hFF;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_SECEN = 12'h008;
  localparam logic [11:0] REG_OPT = 12'h00C;

  localparam int CTL_WP = 0;
  localparam int CTL_CD = 1;
  localparam int CTL_ER = 2;
  localparam int CTL_GO = 3;
  localparam int CTL_TGT = 4;

  localparam int STS_MODE = 0;
  localparam int STS_LOADED = 2;
  localparam int STS_CRC_OK = 3;
  localparam int STS_DELIV = 4;
  localparam int STS_WP = 5;
  localparam int STS_CD = 6;
  localparam int STS_ERASING = 7;
  localparam int STS_APP = 8;
  localparam int STS_MREF = 9;

  // Mode request targets
  localparam logic [1:0] MREQ_BOOT = 2'h0;
  localparam logic [1:0] MREQ_TEST = 2'h1;
  localparam logic [1:0] MREQ_FW = 2'h2;

  typedef enum logic [1:0] {MODE_BOOT, MODE_TEST, MODE_FW} mfg_mode_t;

  typedef enum logic [2:0] {
    ST_LOAD, ST_IDLE, ST_WOCHK, ST_WR, ST_RD, ST_FLAG, ST_ERASE
  } mfg_st_t;

endpackage : mfg_pkg

// *** src/mfg_crc8.sv ***
// Purpose: Byte-serial CRC-8 used to check the fuse transfer.
// Assumes: One byte per cycle while valid_i is high.
// Notes:   clear_i wins over valid_i.
`timescale 1ns/1ps
module mfg_crc8 #(
  parameter logic [7:0] POLY = mfg_pkg::CRC_POLY
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Byte stream
  input wire logic clear_i,
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  // Result
  output logic [7:0] crc_o
);

  typedef struct packed {
    logic [7:0] crc;
  } mfg_crc_state_t;

  mfg_crc_state_t s_q;
  mfg_crc_state_t s_d;

  // Shift one byte in, msb first
  always_comb
  begin
    logic [7:0] c;
    c = s_q.crc ^ data_i;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ POLY) : (c << 1);
    end
    s_d = s_q;
    if (clear_i)
    begin
      s_d.crc = mfg_pkg::CRC_INIT;
    end
    else if (valid_i)
    begin
      s_d.crc = c;
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s_q <= '{crc: mfg_pkg::CRC_INIT};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign crc_o = s_q.crc;

endmodule : mfg_crc8

// *** src/mfg_guard.sv ***
// Purpose: Guards mode switching and the protected fuse row of the NVM.
// Assumes: NVM holds a request until ack; core holds until core_ack_o.
// Notes:   Boot loads four fuse bytes before any core access is served.
`timescale 1ns/1ps

// How it works
// - Boot may go test or firmware, never back.
// - Delivered parts never enter test mode.
// - Boot exists only at start-up; test or firmware after.
// - Top 512 bytes form the guarded row.
// - 32-byte read-only area for applications.
// - 16-byte area writable until protection set.
// - 32-byte area, bits set once only.
// - Configuration area reachable by firmware only.
// - Fuse load at boot checked by CRC.
// - Security enables come only from fuses; all on until a sound fuse load.
// - Triggered card disable blocks later start-ups.
// - Triggered erase clears application memory.
module mfg_guard #(
  parameter int AW = 16,
  parameter int NVM_BYTES = 65536
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Core memory requests
  input wire logic core_req_i,
  input wire logic core_we_i,
  input wire logic core_fw_i,
  input wire logic [AW-1:0] core_addr_i,
  input wire logic [7:0] core_wdata_i,
  output logic core_ack_o,
  output logic core_deny_o,
  output logic [7:0] core_rdata_o,
  // NVM array
  output logic nvm_req_o,
  output logic nvm_we_o,
  output logic [AW-1:0] nvm_addr_o,
  output logic [7:0] nvm_wdata_o,
  input wire logic nvm_ack_i,
  input wire logic [7:0] nvm_rdata_i,
  // Mode and configuration
  output logic [1:0] mode_o,
  output logic app_start_o,
  output logic [7:0] sec_en_o
);

  localparam logic [AW-1:0] ROW_BASE = AW'(NVM_BYTES - mfg_pkg::ROW_BYTES);
  localparam logic [AW-1:0] ERASE_LAST = AW'(ROW_BASE - 1'b1);
  localparam logic [AW-1:0] CFG_BASE = ROW_BASE + AW'(mfg_pkg::CFG_OFF);

  typedef struct packed {
    mfg_pkg::mfg_mode_t mode;
    mfg_pkg::mfg_st_t st;
    logic [AW-1:0] idx;
    logic loaded;
    logic crc_ok;
    logic wp_set;
    logic card_dis;
    logic erasing;
    logic mref;
    logic pend_wp;
    logic pend_cd;
    logic pend_er;
    logic [7:0] sec;
    logic [7:0] opt;
    logic [7:0] sec_en;
    logic app_start;
    logic nreq;
    logic nwe;
    logic [AW-1:0] naddr;
    logic [7:0] nwdata;
    logic cack;
    logic cdeny;
    logic [7:0] crdata;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mfg_state_t;

  mfg_state_t s_q;
  mfg_state_t s_d;
  logic [7:0] crc_val;
  logic [8:0] off;
  logic in_row;
  logic [31:0] status;

  function automatic logic in_rng(input logic [8:0] o, input logic [8:0] b,
                                  input logic [8:0] l);
    return (o >= b) && (o < b + l);
  endfunction : in_rng

  // ---------------------------------------------------------------
  // Fuse transfer checksum
  // ---------------------------------------------------------------
  mfg_crc8 u_crc (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(1'b0),
    .valid_i(s_q.st == mfg_pkg::ST_LOAD && nvm_ack_i
             && s_q.idx[1:0] < mfg_pkg::CFG_CRC),
    .data_i(nvm_rdata_i),
    .crc_o(crc_val)
  );

  // Row-relative offset of the core address
  assign in_row = core_addr_i >= ROW_BASE;
  assign off = 9'(core_addr_i - ROW_BASE);

  // Status word as software sees it
  always_comb
  begin
    status = 32'h0000_0000;
    status[mfg_pkg::STS_MODE +: 2] = s_q.mode;
    status[mfg_pkg::STS_LOADED] = s_q.loaded;
    status[mfg_pkg::STS_CRC_OK] = s_q.crc_ok;
    status[mfg_pkg::STS_DELIV] = s_q.opt[mfg_pkg::OPT_DELIV];
    status[mfg_pkg::STS_WP] = s_q.wp_set;
    status[mfg_pkg::STS_CD] = s_q.card_dis;
    status[mfg_pkg::STS_ERASING] = s_q.erasing;
    status[mfg_pkg::STS_APP] = s_q.app_start;
    status[mfg_pkg::STS_MREF] = s_q.mref;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic wr_acc;
    logic [1:0] tgt;
    wr_acc = psel_i && penable_i && pwrite_i && s_q.pready
             && !s_q.pslverr;
    tgt = pwdata_i[mfg_pkg::CTL_TGT +: 2];
    s_d = s_q;
    s_d.cack = 1'b0;
    s_d.cdeny = 1'b0;
    unique case (s_q.st)
      // Boot reads the fuse bytes one by one
      mfg_pkg::ST_LOAD:
      begin
        if (nvm_ack_i)
        begin
          unique case (s_q.idx[1:0])
            mfg_pkg::CFG_SEC: s_d.sec = nvm_rdata_i;
            mfg_pkg::CFG_OPT: s_d.opt = nvm_rdata_i;
            mfg_pkg::CFG_CRC: s_d.crc_ok = nvm_rdata_i == crc_val;
            mfg_pkg::CFG_STATE:
            begin
              s_d.wp_set = nvm_rdata_i[mfg_pkg::SB_WP];
              s_d.card_dis = nvm_rdata_i[mfg_pkg::SB_CD];
            end
          endcase
          if (s_q.idx[1:0] == mfg_pkg::CFG_STATE)
          begin
            s_d.nreq = 1'b0;
            s_d.loaded = 1'b1;
            s_d.st = mfg_pkg::ST_IDLE;
            // A failed check keeps every mechanism switched on
            s_d.sec_en = s_q.crc_ok ? s_q.sec : mfg_pkg::SEC_FAILSAFE;
          end
          else
          begin
            s_d.idx = s_q.idx + 1'b1;
            s_d.naddr = s_q.naddr + 1'b1;
          end
        end
      end
      // Housekeeping first, then the core
      mfg_pkg::ST_IDLE:
      begin
        if (s_q.pend_er)
        begin
          s_d.pend_er = 1'b0;
          s_d.erasing = 1'b1;
          s_d.st = mfg_pkg::ST_ERASE;
          s_d.idx = '0;
          s_d.nreq = 1'b1;
          s_d.nwe = 1'b1;
          s_d.naddr = '0;
          s_d.nwdata = mfg_pkg::ERASE_VAL;
        end
        else if (s_q.pend_cd || s_q.pend_wp)
        begin
          s_d.pend_cd = 1'b0;
          s_d.pend_wp = 1'b0;
          s_d.card_dis = s_q.card_dis || s_q.pend_cd;
          s_d.wp_set = s_q.wp_set || s_q.pend_wp;
          s_d.st = mfg_pkg::ST_FLAG;
          s_d.nreq = 1'b1;
          s_d.nwe = 1'b1;
          s_d.naddr = CFG_BASE + AW'(mfg_pkg::CFG_STATE);
          s_d.nwdata = 8'h00;
          s_d.nwdata[mfg_pkg::SB_WP] = s_d.wp_set;
          s_d.nwdata[mfg_pkg::SB_CD] = s_d.card_dis;
        end
        else if (core_req_i && !s_q.cack)
        begin
          s_d.nwe = core_we_i;
          s_d.naddr = core_addr_i;
          s_d.nwdata = core_wdata_i;
          s_d.st = core_we_i ? mfg_pkg::ST_WR : mfg_pkg::ST_RD;
          s_d.nreq = 1'b1;
          if (!in_row)
          begin
            s_d.nreq = 1'b1;
          end
          else if (in_rng(off, mfg_pkg::WO_OFF, mfg_pkg::WO_LEN)
                   && core_we_i)
          begin
            // Fetch the old byte to refuse any cleared bit
            s_d.nwe = 1'b0;
            s_d.st = mfg_pkg::ST_WOCHK;
          end
          else if (in_rng(off, mfg_pkg::RO_OFF, mfg_pkg::RO_LEN)
                   && !core_we_i)
          begin
            s_d.nreq = 1'b1;
          end
          else if (in_rng(off, mfg_pkg::WP_OFF, mfg_pkg::WP_LEN)
                   && !(core_we_i && s_q.wp_set))
          begin
            s_d.nreq = 1'b1;
          end
          else if (in_rng(off, mfg_pkg::WO_OFF, mfg_pkg::WO_LEN)
                   || (in_rng(off, mfg_pkg::PDC_OFF, mfg_pkg::PDC_LEN)
                       && core_fw_i))
          begin
            s_d.nreq = 1'b1;
          end
          else
          begin
            // Fuse bytes, gaps and refused writes never reach the array
            s_d.nreq = 1'b0;
            s_d.st = mfg_pkg::ST_IDLE;
            s_d.cack = 1'b1;
            s_d.cdeny = 1'b1;
          end
        end
      end
      mfg_pkg::ST_WOCHK:
      begin
        if (nvm_ack_i)
        begin
          if (|(nvm_rdata_i & ~core_wdata_i))
          begin
            s_d.nreq = 1'b0;
            s_d.st = mfg_pkg::ST_IDLE;
            s_d.cack = 1'b1;
            s_d.cdeny = 1'b1;
          end
          else
          begin
            s_d.nwe = 1'b1;
            s_d.st = mfg_pkg::ST_WR;
          end
        end
      end
      mfg_pkg::ST_WR, mfg_pkg::ST_RD:
      begin
        if (nvm_ack_i)
        begin
          s_d.nreq = 1'b0;
          s_d.st = mfg_pkg::ST_IDLE;
          s_d.cack = 1'b1;
          s_d.crdata = s_q.st == mfg_pkg::ST_RD ? nvm_rdata_i : 8'h00;
        end
      end
      mfg_pkg::ST_FLAG:
      begin
        if (nvm_ack_i)
        begin
          s_d.nreq = 1'b0;
          s_d.st = mfg_pkg::ST_IDLE;
        end
      end
      mfg_pkg::ST_ERASE:
      begin
        if (nvm_ack_i)
        begin
          if (s_q.idx == ERASE_LAST)
          begin
            s_d.nreq = 1'b0;
            s_d.erasing = 1'b0;
            s_d.st = mfg_pkg::ST_IDLE;
          end
          else
          begin
            s_d.idx = s_q.idx + 1'b1;
            s_d.naddr = s_q.idx + 1'b1;
          end
        end
      end
      default:
      begin
        s_d.st = mfg_pkg::ST_IDLE;
        s_d.nreq = 1'b0;
      end
    endcase

    // APB: answer prepared in setup, ready in the first access cycle
    s_d.pready = psel_i && !penable_i && !s_q.pready;
    s_d.pslverr = 1'b0; // Error stands only together with ready
    if (s_d.pready)
    begin
      s_d.prdata = 32'h0000_0000;
      unique case (paddr_i)
        mfg_pkg::REG_CTRL: s_d.prdata = 32'h0000_0000;
        mfg_pkg::REG_STATUS: s_d.prdata = status;
        mfg_pkg::REG_SECEN: s_d.prdata = {24'h000000, s_q.sec_en};
        mfg_pkg::REG_OPT: s_d.prdata = {24'h000000, s_q.opt};
        default: s_d.pslverr = 1'b1;
      endcase
    end

    // Control writes; sets come last so they beat a same-cycle clear
    if (wr_acc && paddr_i == mfg_pkg::REG_CTRL)
    begin
      if (pwdata_i[mfg_pkg::CTL_WP])
      begin
        s_d.pend_wp = 1'b1;
      end
      if (pwdata_i[mfg_pkg::CTL_CD] && s_q.opt[mfg_pkg::OPT_CD_EN])
      begin
        s_d.pend_cd = 1'b1;
      end
      if (pwdata_i[mfg_pkg::CTL_ER] && s_q.opt[mfg_pkg::OPT_ER_EN])
      begin
        s_d.pend_er = 1'b1;
      end
      if (pwdata_i[mfg_pkg::CTL_GO])
      begin
        s_d.mref = 1'b1;
        if (tgt == mfg_pkg::MREQ_TEST && s_q.mode == mfg_pkg::MODE_BOOT
            && s_q.loaded && !s_q.opt[mfg_pkg::OPT_DELIV])
        begin
          s_d.mode = mfg_pkg::MODE_TEST;
          s_d.mref = 1'b0;
        end
        else if (tgt == mfg_pkg::MREQ_FW && (s_q.loaded
                 || s_q.mode != mfg_pkg::MODE_BOOT))
        begin
          s_d.mode = mfg_pkg::MODE_FW;
          s_d.mref = 1'b0;
        end
      end
    end

    // Application runs only from firmware mode on a sound fuse load
    s_d.app_start = s_d.mode == mfg_pkg::MODE_FW && s_d.loaded
                    && s_d.crc_ok && !s_d.card_dis;
  end

  // State register; boot mode exists only from here to the first switch
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s_q <= '0;
      s_q.mode <= mfg_pkg::MODE_BOOT;
      s_q.st <= mfg_pkg::ST_LOAD;
      s_q.nreq <= 1'b1;
      s_q.naddr <= CFG_BASE;
      s_q.sec_en <= mfg_pkg::SEC_FAILSAFE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata_o = s_q.prdata;
  assign pready_o = s_q.pready;
  assign pslverr_o = s_q.pslverr;
  assign core_ack_o = s_q.cack;
  assign core_deny_o = s_q.cdeny;
  assign core_rdata_o = s_q.crdata;
  assign nvm_req_o = s_q.nreq;
  assign nvm_we_o = s_q.nwe;
  assign nvm_addr_o = s_q.naddr;
  assign nvm_wdata_o = s_q.nwdata;
  assign mode_o = s_q.mode;
  assign app_start_o = s_q.app_start;
  assign sec_en_o = s_q.sec_en;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  AST_NO_BOOT_RETURN: assert property (
    s_q.mode != mfg_pkg::MODE_BOOT |=> s_q.mode != mfg_pkg::MODE_BOOT)
    else $error("returned to boot mode");
  AST_TEST_FROM_BOOT: assert property (
    s_q.mode == mfg_pkg::MODE_TEST && $past(s_q.mode) != mfg_pkg::MODE_TEST
    |-> $past(s_q.mode) == mfg_pkg::MODE_BOOT)
    else $error("test mode entered from outside boot");
  AST_NO_TEST_DELIV: assert property (
    s_q.loaded && s_q.opt[mfg_pkg::OPT_DELIV] && s_q.mode != mfg_pkg::MODE_TEST
    |=> s_q.mode != mfg_pkg::MODE_TEST)
    else $error("test mode entered after delivery");
  AST_APP_FW_ONLY: assert property (
    app_start_o |-> s_q.mode == mfg_pkg::MODE_FW && s_q.crc_ok)
    else $error("application started outside firmware mode");
  AST_RO_FUSE_WRITE: assert property (
    nvm_req_o && nvm_we_o && nvm_addr_o >= ROW_BASE
    |-> !in_rng(9'(nvm_addr_o - ROW_BASE), mfg_pkg::RO_OFF, mfg_pkg::RO_LEN))
    else $error("write reached the read-only area");
  AST_WP_DENY: assert property (
    s_q.st == mfg_pkg::ST_IDLE && !s_q.pend_er && !s_q.pend_cd
    && !s_q.pend_wp && core_req_i && core_we_i && !s_q.cack && in_row
    && s_q.wp_set && in_rng(off, mfg_pkg::WP_OFF, mfg_pkg::WP_LEN)
    |=> core_ack_o && core_deny_o && !nvm_req_o)
    else $error("protected area write not refused");
  AST_WO_CLEAR: assert property (
    s_q.st == mfg_pkg::ST_WOCHK && nvm_ack_i
    && |(nvm_rdata_i & ~core_wdata_i)
    |=> core_deny_o && !nvm_req_o ##1 !nvm_we_o)
    else $error("write-once bit cleared");
  AST_PDC_FW: assert property (
    s_q.st == mfg_pkg::ST_IDLE && !s_q.pend_er && !s_q.pend_cd
    && !s_q.pend_wp && core_req_i && !core_fw_i && !s_q.cack && in_row
    && in_rng(off, mfg_pkg::PDC_OFF, mfg_pkg::PDC_LEN)
    |=> core_deny_o)
    else $error("configuration area reached by application");
  AST_CRC_FAIL: assert property (
    $rose(s_q.loaded) && !s_q.crc_ok |-> sec_en_o == mfg_pkg::SEC_FAILSAFE)
    else $error("failed fuse load did not fall back");
  AST_CARD_DIS: assert property (
    s_q.card_dis |-> !app_start_o)
    else $error("disabled card started the application");
  AST_ERASE_DATA: assert property (
    s_q.st == mfg_pkg::ST_ERASE && nvm_req_o
    |-> nvm_we_o && nvm_wdata_o == mfg_pkg::ERASE_VAL && nvm_addr_o < ROW_BASE)
    else $error("erase wrote wrong data or address");

endmodule : mfg_guard

// *** test/mfg_nvm_model.sv ***
// Purpose: Behavioural byte-wide NVM array on the far side of the guard.
// Assumes: Requests are held until ack; ack is a one-cycle pulse.
// Notes:   lat_i sets the wait; idle read data shows the inverted byte.
`timescale 1ns/1ps
module mfg_nvm_model #(
  parameter int AW = 10,
  parameter int NB = 1024
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Array port
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [1:0] lat_i,
  output logic ack_o,
  output logic [7:0] rdata_o
);
  // ---------------------------------------------------------------
  // Storage and answer timing
  // ---------------------------------------------------------------
  logic [7:0] mem [NB];
  logic [7:0] rd_q;
  logic [1:0] cnt_q;

  // Stale data is inverted so a late sample never looks right
  assign rdata_o = ack_o ? rd_q : ~rd_q;

  // Answer after lat_i wait cycles, then let one cycle pass
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ack_o <= 1'b0;
      cnt_q <= 2'h0;
      rd_q <= 8'h00;
    end
    else if (ack_o || !req_i)
    begin
      ack_o <= 1'b0;
      cnt_q <= 2'h0;
    end
    else if (cnt_q >= lat_i)
    begin
      ack_o <= 1'b1;
      rd_q <= mem[addr_i];
      if (we_i)
        mem[addr_i] <= wdata_i;
    end
    else
      cnt_q <= cnt_q + 2'h1;
  end
endmodule : mfg_nvm_model

// *** test/mfg_guard_tb.sv ***
// Purpose: Self-checking bench of the mode and fuse-row guard.
// Assumes: Small array (1 KiB) so an erase stays short.
// Notes:   Fuse bytes are preset in the array model before each boot.
`timescale 1ns/1ps
module mfg_guard_tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int NB = 1024;
  localparam int RB = NB - mfg_pkg::ROW_BYTES;
  localparam int FB = RB + 256;
  localparam logic [7:0] SEC = 8'h5A;
  logic clk_i, reset_i, psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic creq, cwe, cfw, cack, cdeny, nreq, nwe, nack, app, dn;
  logic [9:0] caddr, naddr;
  logic [7:0] cwd, crd, nwd, nrd, sec;
  logic [1:0] mode, lat;
  int err_count, tests_run, cyc;

  mfg_guard #(.AW(10), .NVM_BYTES(NB)) u_dut (.clk_i(clk_i),
    .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .core_req_i(creq), .core_we_i(cwe), .core_fw_i(cfw),
    .core_addr_i(caddr), .core_wdata_i(cwd), .core_ack_o(cack),
    .core_deny_o(cdeny), .core_rdata_o(crd), .nvm_req_o(nreq),
    .nvm_we_o(nwe), .nvm_addr_o(naddr), .nvm_wdata_o(nwd),
    .nvm_ack_i(nack), .nvm_rdata_i(nrd), .mode_o(mode),
    .app_start_o(app), .sec_en_o(sec));
  mfg_nvm_model #(.AW(10), .NB(NB)) u_nvm (.clk_i(clk_i),
    .reset_i(reset_i), .req_i(nreq), .we_i(nwe), .addr_i(naddr),
    .wdata_i(nwd), .lat_i(lat), .ack_o(nack), .rdata_o(nrd));

  // Clock and hang guard
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_count++;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("errors=%0d compares=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    // Wait states are open-ended; only the hang guard ends a stuck wait
    do
    begin
      @(posedge clk_i);
    end
    while (pready !== 1'b1);
    rv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One core byte access; checks whether it was refused
  task automatic core(input logic w, input logic fw, input int a,
                      input logic [7:0] d, input logic xd);
    @(posedge clk_i);
    creq <= 1'b1;
    cwe <= w;
    cfw <= fw;
    caddr <= a[9:0];
    cwd <= d;
    dn = 1'b0;
    while (!dn)
    begin
      @(posedge clk_i);
      dn = (cack === 1'b1);
    end
    chk({31'h0, cdeny}, {31'h0, xd});
    rv = {24'h0, crd};
    creq <= 1'b0;
  endtask : core

  // Preset fuse bytes (CRC over bytes 0-1, MSB first) and reboot
  task automatic boot(input logic [7:0] opt, input logic [7:0] st,
                      input logic bad);
    logic [7:0] c;
    logic [15:0] m;
    c = mfg_pkg::CRC_INIT;
    m = {SEC, opt};
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ (c[7] ^ m[i] ? mfg_pkg::CRC_POLY : 8'h00);
    u_nvm.mem[FB] = SEC;
    u_nvm.mem[FB+1] = opt;
    u_nvm.mem[FB+2] = c ^ {7'h0, bad};
    u_nvm.mem[FB+3] = st;
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 50; i++)
    begin
      apb(1'b0, mfg_pkg::REG_STATUS, 32'h0);
      if (rv[2] === 1'b1)
        break;
    end
  endtask : boot

  // Request a mode and compare the mode output afterwards
  task automatic go(input logic [1:0] t, input logic [1:0] m);
    apb(1'b1, mfg_pkg::REG_CTRL, {26'h0, t, 4'h8});
    @(posedge clk_i);
    chk({30'h0, mode}, {30'h0, m});
  endtask : go

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    boot(8'h00, 8'h00, 1'b0);
    chk(rv & 32'h3FF, 32'h00C);
    apb(1'b1, mfg_pkg::REG_SECEN, 32'h0);
    apb(1'b0, mfg_pkg::REG_SECEN, 32'h0);
    chk(rv & 32'hFF, {24'h0, SEC});
    chk({24'h0, sec}, {24'h0, SEC});
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, perr}, 32'h1);
  endtask : t_regs

  task automatic t_modes();
    go(mfg_pkg::MREQ_BOOT, 2'h0);
    go(mfg_pkg::MREQ_FW, 2'h2);
    chk({31'h0, app}, 32'h1);
    go(mfg_pkg::MREQ_TEST, 2'h2);
    go(mfg_pkg::MREQ_BOOT, 2'h2);
    boot(8'h00, 8'h00, 1'b0);
    go(mfg_pkg::MREQ_TEST, 2'h1);
    go(mfg_pkg::MREQ_BOOT, 2'h1);
    go(mfg_pkg::MREQ_FW, 2'h2);
    boot(8'h04, 8'h00, 1'b0);
    apb(1'b0, mfg_pkg::REG_OPT, 32'h0);
    chk(rv, 32'h4);
    go(mfg_pkg::MREQ_TEST, 2'h0);
    go(mfg_pkg::MREQ_FW, 2'h2);
  endtask : t_modes

  task automatic t_row();
    lat <= 2'h0;
    u_nvm.mem[RB] = 8'hA5;
    u_nvm.mem[RB+64] = 8'h00;
    boot(8'h00, 8'h00, 1'b0);
    core(1'b0, 1'b0, RB, 8'h00, 1'b0);
    chk(rv, 32'hA5);
    core(1'b1, 1'b0, RB, 8'h00, 1'b1);
    chk({24'h0, u_nvm.mem[RB]}, 32'hA5);
    core(1'b1, 1'b0, RB + 32, 8'h11, 1'b0);
    apb(1'b1, mfg_pkg::REG_CTRL, 32'h1);
    core(1'b1, 1'b0, RB + 32, 8'h22, 1'b1);
    chk({24'h0, u_nvm.mem[RB+32]}, 32'h11);
    core(1'b1, 1'b0, RB + 64, 8'h0F, 1'b0);
    core(1'b1, 1'b0, RB + 64, 8'h03, 1'b1);
    core(1'b1, 1'b0, RB + 64, 8'h1F, 1'b0);
    chk({24'h0, u_nvm.mem[RB+64]}, 32'h1F);
    core(1'b0, 1'b0, RB + 128, 8'h00, 1'b1);
    core(1'b0, 1'b1, RB + 128, 8'h00, 1'b0);
    core(1'b1, 1'b1, FB, 8'h00, 1'b1);
    core(1'b1, 1'b0, RB - 1, 8'h3C, 1'b0);
    chk({24'h0, u_nvm.mem[RB-1]}, 32'h3C);
  endtask : t_row

  task automatic t_cd_erase();
    lat <= 2'h3;
    boot(8'h01, 8'h00, 1'b0);
    go(mfg_pkg::MREQ_FW, 2'h2);
    chk({31'h0, app}, 32'h1);
    apb(1'b1, mfg_pkg::REG_CTRL, 32'h2);
    core(1'b0, 1'b0, 0, 8'h00, 1'b0);
    chk({24'h0, u_nvm.mem[FB+3]}, 32'h2);
    boot(8'h01, u_nvm.mem[FB+3], 1'b0);
    go(mfg_pkg::MREQ_FW, 2'h2);
    chk({31'h0, app}, 32'h0);
    u_nvm.mem[0] = 8'h77;
    boot(8'h00, 8'h00, 1'b0);
    apb(1'b1, mfg_pkg::REG_CTRL, 32'h6);
    core(1'b0, 1'b0, 0, 8'h00, 1'b0);
    chk(rv, 32'h77);
    apb(1'b0, mfg_pkg::REG_STATUS, 32'h0);
    chk({31'h0, rv[6]}, 32'h0);
    boot(8'h02, 8'h00, 1'b0);
    apb(1'b1, mfg_pkg::REG_CTRL, 32'h4);
    for (int i = 0; i < 3000; i++)
    begin
      apb(1'b0, mfg_pkg::REG_STATUS, 32'h0);
      if (rv[7] === 1'b0)
        break;
    end
    chk({24'h0, u_nvm.mem[0]}, 32'h0);
    chk({24'h0, u_nvm.mem[RB-1]}, 32'h0);
    chk({24'h0, u_nvm.mem[RB]}, 32'hA5);
    boot(8'h00, 8'h00, 1'b1);
    chk({31'h0, rv[3]}, 32'h0);
    chk({24'h0, sec}, 32'hFF);
  endtask : t_cd_erase

  // Main sequence
  initial
  begin
    {psel, penable, pwrite, creq, cwe, cfw} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    caddr = 10'h000;
    cwd = 8'h00;
    lat = 2'h1;
    reset_i = 1'b1;
    err_count = 0;
    tests_run = 0;
    cyc = 0;
    t_regs();
    t_modes();
    t_row();
    t_cd_erase();
    close_out();
  end
endmodule : mfg_guard_tb
